// *** design/tm0_pkg.sv ***
// Purpose: Shared constants for the timer0 register block and shared prescaler.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Register offsets are byte addresses.
package tm0_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_COMPARE = 8'h04;
	localparam logic [7:0] OFS_ENABLES = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_SFR = 8'h10;
	localparam logic [7:0] OFS_CONTROL = 8'h14;

	// Values after reset
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_COMPARE = 8'h00;
	localparam logic [1:0] RST_ENABLES = 2'h0;
	localparam logic [1:0] RST_FLAGS = 2'h0;
	localparam logic [2:0] RST_CLK_SEL = 3'h0;
	localparam logic [9:0] RST_PRESCALE = 10'h000;

	// Field positions
	localparam int BIT_OVF = 0;
	localparam int BIT_CMP = 1;
	localparam int BIT_PRESCALER_RESET = 0;
	localparam int CTL_T0_SEL_LSB = 0;
	localparam int CTL_T1_SEL_LSB = 4;
	localparam int CTL_PHASE_CORRECT = 8;
	localparam int CTL_GLOBAL_IRQ = 9;

	// Counter limits
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;

	// Prescaler tap widths (log2 of divisor)
	localparam int TAP8_BITS = 3;
	localparam int TAP64_BITS = 6;
	localparam int TAP256_BITS = 8;
	localparam int TAP1024_BITS = 10;

	// Clock select codes
	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIRECT = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} tm0_clk_sel_t;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} tm0_dir_t;

endpackage

// *** design/tm0_prescaler.sv ***
// Purpose: Free-running 10-bit prescaler shared by both timers.
// Assumes: One clock, synchronous restart strobe.
// Notes: Tap pulses are one cycle wide, one per divisor period.
`timescale 1ns/1ps
`default_nettype none
module tm0_prescaler
	import tm0_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	output logic tick_div8,
	output logic tick_div64,
	output logic tick_div256,
	output logic tick_div1024
);

	logic [9:0] count_ff;
	logic [9:0] nxt_count;

	// Runs regardless of any clock select; only restart touches it
	assign nxt_count = restart ? RST_PRESCALE : count_ff + 10'h001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= RST_PRESCALE;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign tick_div8 = &count_ff[TAP8_BITS-1:0];
	assign tick_div64 = &count_ff[TAP64_BITS-1:0];
	assign tick_div256 = &count_ff[TAP256_BITS-1:0];
	assign tick_div1024 = &count_ff[TAP1024_BITS-1:0];

endmodule
`default_nettype wire

// *** design/tm0_pin_edge.sv ***
// Purpose: Synchroniser and edge detector for the external count pin.
// Assumes: Pin is asynchronous to pclk.
// Notes: Pulses are one pclk cycle, combinational from flops.
`timescale 1ns/1ps
`default_nettype none
module tm0_pin_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_async,
	output logic rise_pulse,
	output logic fall_pulse
);

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// Stands in for the transparent latch plus sampling flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= pin_async;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign rise_pulse = sync_ff & ~prev_ff;
	assign fall_pulse = ~sync_ff & prev_ff;

endmodule
`default_nettype wire

// *** design/tm0_timer_regs.sv ***
// Purpose: Timer0 counter, compare, flags, enables and clock select over APB.
// Assumes: APB slave, 32-bit data, byte addresses, one wait state per access.
// Notes: Second timer only receives its selected tick (direct, shared prescaler tap or pin edge).
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tm0_timer_regs
	import tm0_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_count_pin,
	input wire logic compare_vector_ack,
	input wire logic overflow_vector_ack,
	output logic compare_irq_req,
	output logic overflow_irq_req,
	output logic compare_match_pulse,
	output logic timer_count_tick,
	output logic timer1_tick
);

	// Register state
	logic [7:0] count_ff;
	logic [7:0] compare_ff;
	logic [1:0] enables_ff;
	logic [1:0] flags_ff;
	logic [2:0] t0_sel_ff;
	logic [2:0] t1_sel_ff;
	logic phase_correct_ff;
	logic global_irq_ff;
	tm0_dir_t dir_ff;
	logic block_match_ff;
	logic prescaler_reset_ff;

	// Bus state
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	// Output flops
	logic compare_irq_ff;
	logic overflow_irq_ff;
	logic match_pulse_ff;
	logic tick_ff;
	logic t1_tick_ff;

	// Next values
	logic [7:0] nxt_count;
	tm0_dir_t nxt_dir;
	logic [1:0] nxt_flags;
	logic nxt_block_match;

	// Tap and pin pulses
	logic tick_div8;
	logic tick_div64;
	logic tick_div256;
	logic tick_div1024;
	logic pin_rise;
	logic pin_fall;

	// Tick selection, shared by both timers
	function automatic logic sel_tick(
		input logic [2:0] sel,
		input logic d8,
		input logic d64,
		input logic d256,
		input logic d1024,
		input logic rise,
		input logic fall
	);
		logic t;
		t = 1'b0;
		case (sel)
			CS_STOP: t = 1'b0;
			CS_DIRECT: t = 1'b1;
			CS_DIV8: t = d8;
			CS_DIV64: t = d64;
			CS_DIV256: t = d256;
			CS_DIV1024: t = d1024;
			CS_EXT_FALL: t = fall;
			CS_EXT_RISE: t = rise;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	tm0_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.restart(prescaler_reset_ff),
		.tick_div8(tick_div8),
		.tick_div64(tick_div64),
		.tick_div256(tick_div256),
		.tick_div1024(tick_div1024)
	);

	// two-flop sample, roughly three cycles to count
	tm0_pin_edge u_pin_edge (
		.pclk(pclk),
		.presetn(presetn),
		.pin_async(external_count_pin),
		.rise_pulse(pin_rise),
		.fall_pulse(pin_fall)
	);

	// Bus decode
	wire access_done = psel & penable & pready_ff;
	wire wr_done = access_done & pwrite;
	wire hit_count = (paddr == OFS_COUNT);
	wire hit_compare = (paddr == OFS_COMPARE);
	wire hit_enables = (paddr == OFS_ENABLES);
	wire hit_flags = (paddr == OFS_FLAGS);
	wire hit_sfr = (paddr == OFS_SFR);
	wire hit_control = (paddr == OFS_CONTROL);
	wire hit_any = hit_count | hit_compare | hit_enables | hit_flags | hit_sfr | hit_control;
	wire wr_count = wr_done & hit_count;
	wire wr_compare = wr_done & hit_compare;
	wire wr_enables = wr_done & hit_enables;
	wire wr_flags = wr_done & hit_flags;
	wire wr_sfr = wr_done & hit_sfr;
	wire wr_control = wr_done & hit_control;

	// taps come from the free counter, phase not aligned to enable
	wire t0_tick = sel_tick(t0_sel_ff, tick_div8, tick_div64, tick_div256,
		tick_div1024, pin_rise, pin_fall);
	wire t1_tick = sel_tick(t1_sel_ff, tick_div8, tick_div64, tick_div256,
		tick_div1024, pin_rise, pin_fall);

	wire count_equal = (count_ff == compare_ff);
	wire cmp_event = t0_tick & count_equal & ~block_match_ff;

	// Counting direction; phase-correct turns at the ends
	wire at_max = (count_ff == COUNT_MAX);
	wire at_bottom = (count_ff == COUNT_BOTTOM);
	// overflow on wrap, or on turn at bottom in phase-correct
	wire ovf_event = t0_tick & (phase_correct_ff ?
		(at_bottom & (dir_ff == DIR_DOWN)) : at_max);

	// tick used as single-cycle count enable
	always_comb begin
		nxt_count = count_ff;
		nxt_dir = dir_ff;
		if (t0_tick) begin
			if (phase_correct_ff) begin
				if (dir_ff == DIR_UP) begin
					if (at_max) begin
						nxt_dir = DIR_DOWN;
						nxt_count = count_ff - 8'h01;
					end else begin
						nxt_count = count_ff + 8'h01;
					end
				end else begin
					if (at_bottom) begin
						nxt_dir = DIR_UP;
						nxt_count = count_ff + 8'h01;
					end else begin
						nxt_count = count_ff - 8'h01;
					end
				end
			end else begin
				nxt_dir = DIR_UP;
				nxt_count = count_ff + 8'h01;
			end
		end
		// software write wins over a tick
		if (wr_count) begin
			nxt_count = pwdata[7:0];
		end
	end

	// block held until the next timer tick
	always_comb begin
		nxt_block_match = block_match_ff;
		if (t0_tick) begin
			nxt_block_match = 1'b0;
		end
		if (wr_count) begin
			nxt_block_match = 1'b1;
		end
	end

	// Flags: hardware set wins over any clear in the same cycle
	always_comb begin
		nxt_flags = flags_ff;
		if (wr_flags) begin
			nxt_flags = nxt_flags & ~pwdata[1:0];
		end
		if (compare_vector_ack) begin
			nxt_flags[BIT_CMP] = 1'b0;
		end
		if (overflow_vector_ack) begin
			nxt_flags[BIT_OVF] = 1'b0;
		end
		if (cmp_event) begin
			nxt_flags[BIT_CMP] = 1'b1;
		end
		if (ovf_event) begin
			nxt_flags[BIT_OVF] = 1'b1;
		end
	end

	// Read mux
	wire [31:0] rd_count = {24'h00_0000, count_ff};
	wire [31:0] rd_compare = {24'h00_0000, compare_ff};
	wire [31:0] rd_enables = {30'h0000_0000, enables_ff};
	wire [31:0] rd_flags = {30'h0000_0000, flags_ff};
	wire [31:0] rd_control = {22'h00_0000, global_irq_ff, phase_correct_ff,
		1'b0, t1_sel_ff, 1'b0, t0_sel_ff};
	// prescaler reset bit always reads zero
	wire [31:0] rd_data = hit_count ? rd_count :
		hit_compare ? rd_compare :
		hit_enables ? rd_enables :
		hit_flags ? rd_flags :
		hit_control ? rd_control : 32'h0000_0000;

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~hit_any;
			if (psel & penable & ~pready_ff & ~pwrite) begin
				prdata_ff <= rd_data;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= RST_COUNT;
			dir_ff <= DIR_UP;
			block_match_ff <= 1'b0;
			flags_ff <= RST_FLAGS;
		end else begin
			count_ff <= nxt_count;
			dir_ff <= nxt_dir;
			block_match_ff <= nxt_block_match;
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_ff <= RST_COMPARE;
			enables_ff <= RST_ENABLES;
		end else begin
			if (wr_compare) begin
				compare_ff <= pwdata[7:0];
			end
			if (wr_enables) begin
				enables_ff <= pwdata[1:0];
			end
		end
	end

	// Clock select and mode bits; a switch to external is safe only on a stable pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0_sel_ff <= RST_CLK_SEL;
			t1_sel_ff <= RST_CLK_SEL;
			phase_correct_ff <= 1'b0;
			global_irq_ff <= 1'b0;
		end else if (wr_control) begin
			t0_sel_ff <= pwdata[CTL_T0_SEL_LSB +: 3];
			t1_sel_ff <= pwdata[CTL_T1_SEL_LSB +: 3];
			phase_correct_ff <= pwdata[CTL_PHASE_CORRECT];
			global_irq_ff <= pwdata[CTL_GLOBAL_IRQ];
		end
	end

	// write-one strobe, self-clearing after one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler_reset_ff <= 1'b0;
		end else begin
			prescaler_reset_ff <= wr_sfr & pwdata[BIT_PRESCALER_RESET];
		end
	end

	// Request outputs follow flags one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_irq_ff <= 1'b0;
			overflow_irq_ff <= 1'b0;
			match_pulse_ff <= 1'b0;
			tick_ff <= 1'b0;
			t1_tick_ff <= 1'b0;
		end else begin
			compare_irq_ff <= enables_ff[BIT_CMP] & global_irq_ff & flags_ff[BIT_CMP];
			overflow_irq_ff <= enables_ff[BIT_OVF] & global_irq_ff & flags_ff[BIT_OVF];
			// match pulse for the waveform unit
			match_pulse_ff <= cmp_event;
			tick_ff <= t0_tick;
			t1_tick_ff <= t1_tick;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign compare_irq_req = compare_irq_ff;
	assign overflow_irq_req = overflow_irq_ff;
	assign compare_match_pulse = match_pulse_ff;
	assign timer_count_tick = tick_ff;
	assign timer1_tick = t1_tick_ff;

endmodule
`default_nettype wire

// *** test/tm0_sva.sv ***
// Purpose: Port checker for the timer0 register block
// Assumes: One clock, async active-low reset
// Notes: Mirrors timer0 clock select from APB writes
`timescale 1ns/1ps
`default_nettype none
module tm0_sva
	import tm0_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic external_count_pin,
	input wire logic compare_vector_ack,
	input wire logic overflow_vector_ack,
	input wire logic compare_irq_req,
	input wire logic overflow_irq_req,
	input wire logic compare_match_pulse,
	input wire logic timer_count_tick
);
	logic [2:0] sel0_ff;
	wire logic ctl_wr = psel && penable && pready && pwrite && paddr == OFS_CONTROL;
	wire logic bad_addr = paddr > OFS_CONTROL || paddr[1:0] != 2'b00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sel0_ff <= RST_CLK_SEL;
		else if (ctl_wr)
			sel0_ff <= pwdata[2:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Set in the same cycle wins, so only acks without a fresh event count
	property pin_rise_p;
		sel0_ff == CS_EXT_RISE && $rose(external_count_pin) |-> ##[2:5] timer_count_tick;
	endproperty
	property cmp_clear_p;
		compare_vector_ack ##1 !compare_match_pulse |=> !compare_irq_req;
	endproperty
	property ovf_clear_p;
		overflow_vector_ack ##1 !timer_count_tick |=> !overflow_irq_req;
	endproperty
	apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready not on second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	bad_addr_a: assert property (psel && penable && pready |-> pslverr == bad_addr)
		else $error("error response does not match address");
	direct_tick_a: assert property ((sel0_ff == CS_DIRECT)[*3] |-> timer_count_tick)
		else $error("direct clock missed a tick");
	stopped_tick_a: assert property ((sel0_ff == CS_STOP)[*3] |-> !timer_count_tick)
		else $error("tick while stopped");
	pin_rise_a: assert property (pin_rise_p)
		else $error("pin edge not counted in time");
	cmp_clear_a: assert property (cmp_clear_p)
		else $error("compare request stays after vector");
	ovf_clear_a: assert property (ovf_clear_p)
		else $error("overflow request stays after vector");
	cover property (compare_match_pulse);
	cover property (compare_irq_req);
	cover property (overflow_irq_req);
endmodule
bind tm0_timer_regs tm0_sva chk (.*);
`default_nettype wire

// *** test/tm0_ext_src.sv ***
// Purpose: External clock source on the count pin
// Assumes: Unrelated to pclk in phase
// Notes: One burst of pulses per rising start
`timescale 1ns/1ps
`default_nettype none
module tm0_ext_src #(
	parameter int PULSES = 5,
	parameter int HALF_NS = 100
) (
	input wire logic start,
	output logic pin
);
	initial pin = 1'b0;
	always @(posedge start) begin
		// Small offset keeps every pin change off the pclk rising edges
		#3;
		repeat (PULSES) begin
			#HALF_NS pin = 1'b1;
			#HALF_NS pin = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** test/timer0_flags_and_prescaler_test.sv ***
// Purpose: Register, flag, prescaler and pin tests for timer0
// Assumes: APB answers with one wait state
// Notes: Tick windows span whole prescaler periods
`timescale 1ns/1ps
`default_nettype none
module timer0_flags_and_prescaler_test
	import tm0_pkg::*;
();
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, pin, start = 1'b0, cack = 1'b0, oack = 1'b0;
	logic cirq, oirq, cmatch, t0_tick, t1_tick, slv;
	int errors = 0, num_checks = 0, t0n = 0, t1n = 0, gap [2];
	int div [6] = '{0, 1, 8, 64, 256, 1024};
	always #20 pclk = ~pclk;
	// Non-blocking so reads at an edge see a stable total
	always @(posedge pclk) begin
		t0n <= t0n + int'(t0_tick);
		t1n <= t1n + int'(t1_tick);
	end
	tm0_timer_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_count_pin(pin), .compare_vector_ack(cack),
		.overflow_vector_ack(oack), .compare_irq_req(cirq), .overflow_irq_req(oirq),
		.compare_match_pulse(cmatch), .timer_count_tick(t0_tick), .timer1_tick(t1_tick));
	tm0_ext_src #(.PULSES(5), .HALF_NS(100)) ext (.start(start), .pin(pin));
	task automatic test_done;
		if (errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, q, exp);
	endtask
	task automatic pulse_ack(input logic c);
		@(posedge pclk);
		cack <= c;
		oack <= !c;
		@(posedge pclk);
		cack <= 1'b0;
		oack <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] s0, input logic [2:0] s1, input logic g);
		return (32'(g) << CTL_GLOBAL_IRQ) | (32'(s1) << CTL_T1_SEL_LSB) | 32'(s0);
	endfunction
	// Run the counter briefly at full rate, then stop it
	task automatic burst(input logic g);
		wr(OFS_CONTROL, ctl(CS_DIRECT, CS_STOP, 1'b1));
		repeat (4) @(posedge pclk);
		wr(OFS_CONTROL, ctl(CS_STOP, CS_STOP, g));
	endtask
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		test_done;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 24; a += 4) begin
			rd(8'(a), 32'h0000_0000, "reset value");
			chk("error response", 32'(slv), 32'(a == 24));
		end
		wr(OFS_COUNT, 32'h0000_005A);
		wr(OFS_COMPARE, 32'h0000_0080);
		repeat (20) @(posedge pclk);
		rd(OFS_COUNT, 32'h0000_005A, "stopped count");
		rd(OFS_COMPARE, 32'h0000_0080, "compare");
		wr(OFS_ENABLES, 32'h0000_0003);
		wr(OFS_COUNT, 32'h0000_00FE);
		burst(1'b1);
		rd(OFS_FLAGS, 32'h0000_0001, "overflow flag");
		chk("overflow request", 32'(oirq), 32'h1);
		chk("compare request", 32'(cirq), 32'h0);
		wr(OFS_FLAGS, 32'h0000_0000);
		rd(OFS_FLAGS, 32'h0000_0001, "flag after zero");
		pulse_ack(1'b0);
		rd(OFS_FLAGS, 32'h0000_0000, "flag after vector");
		chk("overflow request", 32'(oirq), 32'h0);
		wr(OFS_COUNT, 32'h0000_007E);
		burst(1'b0);
		rd(OFS_FLAGS, 32'h0000_0002, "compare flag");
		chk("masked request", 32'(cirq), 32'h0);
		wr(OFS_CONTROL, ctl(CS_STOP, CS_STOP, 1'b1));
		repeat (2) @(posedge pclk);
		chk("compare request", 32'(cirq), 32'h1);
		wr(OFS_FLAGS, 32'h0000_0002);
		rd(OFS_FLAGS, 32'h0000_0000, "flag after one");
		// Set the compare flag again so the vector clear has work to do
		wr(OFS_COUNT, 32'h0000_007E);
		burst(1'b1);
		chk("compare request", 32'(cirq), 32'h1);
		pulse_ack(1'b1);
		chk("compare request", 32'(cirq), 32'h0);
		rd(OFS_FLAGS, 32'h0000_0000, "compare after vector");
		wr(OFS_CONTROL, ctl(CS_DIRECT, CS_STOP, 1'b1));
		wr(OFS_COUNT, 32'h0000_0080);
		wr(OFS_CONTROL, ctl(CS_STOP, CS_STOP, 1'b1));
		rd(OFS_FLAGS, 32'h0000_0000, "blocked match");
		// Phase-correct: no overflow at the top turn, only at the bottom one
		wr(OFS_COUNT, 32'h0000_00FE);
		wr(OFS_CONTROL, (32'h0000_0001 << CTL_PHASE_CORRECT) | ctl(CS_DIRECT, CS_STOP, 1'b0));
		repeat (4) @(posedge pclk);
		rd(OFS_FLAGS, 32'h0000_0000, "top turn");
		repeat (300) @(posedge pclk);
		rd(OFS_FLAGS, 32'h0000_0003, "bottom turn");
		wr(OFS_CONTROL, ctl(CS_STOP, CS_STOP, 1'b0));
		for (int i = 1; i <= 5; i++) begin
			wr(OFS_CONTROL, ctl(3'(i), 3'(6 - i), 1'b0));
			// First count lands within one divisor period plus the output flop
			gap[0] = 0;
			while (t0_tick !== 1'b1 && gap[0] <= div[i] + 1) begin
				@(posedge pclk);
				gap[0]++;
			end
			chk("first tick", 32'(gap[0] <= div[i] + 1), 32'h0000_0001);
			repeat (3) @(posedge pclk);
			gap[0] = t0n;
			gap[1] = t1n;
			repeat (4096) @(posedge pclk);
			chk("timer0 ticks", t0n - gap[0], 4096 / div[i]);
			chk("timer1 ticks", t1n - gap[1], 4096 / div[6 - i]);
		end
		wr(OFS_CONTROL, ctl(CS_STOP, CS_DIV1024, 1'b0));
		for (int k = 0; k < 2; k++) begin
			repeat (300 * k + 5) @(posedge pclk);
			wr(OFS_SFR, 32'h0000_0001);
			// Skip ticks already on their way from the old phase
			repeat (3) @(posedge pclk);
			gap[k] = 0;
			while (t1_tick !== 1'b1) begin
				@(posedge pclk);
				gap[k]++;
			end
		end
		chk("restart phase", gap[0], gap[1]);
		rd(OFS_SFR, 32'h0000_0000, "restart bit");
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CONTROL, ctl(k ? CS_EXT_FALL : CS_EXT_RISE, CS_STOP, 1'b0));
			wr(OFS_COUNT, 32'h0000_0000);
			start <= 1'b1;
			repeat (40) @(posedge pclk);
			start <= 1'b0;
			rd(OFS_COUNT, 32'h0000_0005, "pin edges");
		end
		test_done;
	end
endmodule
`default_nettype wire
